// [adc_conversion_control.sv]
`include "adc_ctrl_params.svh"
`default_nettype none
// Notes on behaviour
// - Two control registers; result in high/low pair.
// - Result is straight binary, FS/4096 steps.
// - Channel number fills top nibble of high.
// - Power mode field selects four power modes.
// - Powered down keeps reference on, rest off.
// - Clock divide field divides by 1,2,4,8.
// - A conversion takes 17 converter clocks.
// - Acquisition lasts 1,2,4 or 8 converter clocks.
// - Timer trigger starts on second overflow.
// - Active-low external pulse starts conversion.
// - Single and continuous, software or pin.
// - DMA mode converts continuously into external memory.
// - Factory calibration loaded at power-up, rewritable.
// - Temperature reference offered as ninth channel.
// - Done flag set at end of single or DMA conversion, cleared on vector.
// - Single request bit clears on completion.
// - Continuous bit restarts after each conversion.
// - Channel from select bits, DMA from memory.
module adc_conversion_control #(
  parameter logic [7:0] FACTORY_OFFSET = 8'h80, // Arbitrary default.
  parameter logic [7:0] FACTORY_GAIN = 8'h80 // Arbitrary default.
) (
  // Clock and reset.
  input wire logic i_mclk,
  input wire logic i_sys_rst,
  // Special function register port.
  input wire adc_ctrl_pkg::sfr_req_t i_sfr,
  output logic [7:0] o_sfr_rdata,
  // Trigger sources and service acknowledge.
  input wire logic i_timer2_ovf,
  input wire logic i_ext_convert_n,
  input wire logic i_int_vector_ack,
  // Analog core.
  input wire logic [11:0] i_sar_code,
  input wire logic i_sar_bit_temp,
  output logic o_ref_power_en,
  output logic o_core_power_en,
  output logic o_core_standby,
  output logic o_track,
  output logic o_sar_clk_en,
  output logic [3:0] o_mux_chan,
  output logic o_conv_done_flag,
  // DMA capture.
  input wire logic [3:0] i_dma_chan_id,
  output logic o_dma_req,
  output logic [11:0] o_dma_sample,
  output logic [3:0] o_dma_chan,
  // Calibration coefficients.
  output logic [7:0] o_offset_cal,
  output logic [7:0] o_gain_cal
);

  // ****************************************
  // Registers and decode
  // ****************************************
  adc_ctrl_pkg::timing_ctrl_t timing;
  adc_ctrl_pkg::mode_ctrl_t mode;
  adc_ctrl_pkg::conv_state_t state;
  logic [7:0] result_high;
  logic [7:0] result_low;
  logic [2:0] div_cnt;
  logic [4:0] clk_cnt;
  logic [3:0] conv_chan;
  logic timer_armed;
  logic [3:0] ext_low_cnt;
  logic ext_seen;

  function automatic logic [3:0] code_to_count(input logic [1:0] code);
    code_to_count = 4'h1 << code;
  endfunction

  wire wr_timing = i_sfr.wr && (i_sfr.addr == `ADDR_TIMING_CTRL);
  wire wr_mode = i_sfr.wr && (i_sfr.addr == `ADDR_MODE_CTRL);
  wire adc_ctrl_pkg::mode_ctrl_t mode_wdata = i_sfr.wdata;
  wire wr_offs = i_sfr.wr && (i_sfr.addr == `ADDR_OFFSET_CAL);
  wire wr_gain = i_sfr.wr && (i_sfr.addr == `ADDR_GAIN_CAL);
  wire [3:0] div_len = code_to_count(timing.clk_div);
  wire [3:0] acq_len = code_to_count(timing.acq_time);
  wire adc_tick = ({1'b0, div_cnt} == div_len - 4'h1);
  wire idle = (state == adc_ctrl_pkg::ST_IDLE);
  wire timer_trig = timing.timer_trigger_en && i_timer2_ovf && timer_armed;
  wire ext_trig = timing.ext_trigger_en && !i_ext_convert_n && !ext_seen
    && (ext_low_cnt >= 4'(`EXT_PULSE_CYC - 1));
  wire sw_trig = mode.single_conv_req || mode.continuous_conv_en || mode.dma_en;
  wire powered = (timing.power_mode != `PWR_DOWN);
  wire start = idle && powered && (sw_trig || timer_trig || ext_trig);
  wire conv_end = (state == adc_ctrl_pkg::ST_CONV) && adc_tick
    && (clk_cnt == `CONV_CLKS - 5'h1);
  wire acq_end = (state == adc_ctrl_pkg::ST_ACQ) && adc_tick
    && (clk_cnt == {1'b0, acq_len} - 5'h1);
  wire [3:0] next_chan = mode.dma_en ? i_dma_chan_id : mode.chan_sel;
  wire [11:0] sample = (conv_chan == `TEMP_CHAN) ? {11'h000, i_sar_bit_temp}
    : i_sar_code;

  logic [7:0] next_rdata;
  always_comb begin
    case (i_sfr.addr)
      `ADDR_TIMING_CTRL: next_rdata = timing;
      `ADDR_MODE_CTRL: next_rdata = mode;
      `ADDR_RESULT_HIGH: next_rdata = result_high;
      `ADDR_RESULT_LOW: next_rdata = result_low;
      `ADDR_OFFSET_CAL: next_rdata = o_offset_cal;
      `ADDR_GAIN_CAL: next_rdata = o_gain_cal;
      default: next_rdata = 8'h00;
    endcase
  end

  // ****************************************
  // Register file
  // ****************************************
  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      timing <= `RST_TIMING_CTRL;
      mode <= `RST_MODE_CTRL;
      o_offset_cal <= FACTORY_OFFSET;
      o_gain_cal <= FACTORY_GAIN;
      o_sfr_rdata <= 8'h00;
    end else begin
      o_sfr_rdata <= i_sfr.rd ? next_rdata : 8'h00;
      if (wr_timing) timing <= i_sfr.wdata;
      if (wr_offs) o_offset_cal <= i_sfr.wdata;
      if (wr_gain) o_gain_cal <= i_sfr.wdata;
      if (wr_mode) begin
        mode <= i_sfr.wdata;
      end
      // Hardware set wins over any clear in the same cycle.
      if (conv_end && (mode.single_conv_req || mode.dma_en)) begin
        mode.conv_done_flag <= 1'b1;
      end else if (i_int_vector_ack) begin
        mode.conv_done_flag <= 1'b0;
      end
      if (conv_end && !(wr_mode && mode_wdata.single_conv_req)) begin
        mode.single_conv_req <= 1'b0;
      end
    end
  end

  // ****************************************
  // Trigger qualification
  // ****************************************
  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      timer_armed <= 1'b0;
      ext_low_cnt <= 4'h0;
      ext_seen <= 1'b0;
    end else begin
      if (!timing.timer_trigger_en) timer_armed <= 1'b0;
      else if (i_timer2_ovf) timer_armed <= 1'b1;
      if (i_ext_convert_n) begin
        ext_low_cnt <= 4'h0;
        ext_seen <= 1'b0;
      end else begin
        if (ext_low_cnt != 4'hf) ext_low_cnt <= ext_low_cnt + 4'h1;
        if (ext_trig) ext_seen <= 1'b1;
      end
    end
  end

  // ****************************************
  // Conversion sequencer
  // ****************************************
  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      state <= adc_ctrl_pkg::ST_IDLE;
      div_cnt <= 3'h0;
      clk_cnt <= 5'h00;
      conv_chan <= 4'h0;
      result_high <= 8'h00;
      result_low <= 8'h00;
    end else begin
      div_cnt <= (idle || adc_tick) ? 3'h0 : div_cnt + 3'h1;
      case (state)
        adc_ctrl_pkg::ST_IDLE: begin
          clk_cnt <= 5'h00;
          if (start) begin
            state <= adc_ctrl_pkg::ST_ACQ;
            conv_chan <= next_chan;
          end
        end
        adc_ctrl_pkg::ST_ACQ: begin
          if (acq_end) begin
            state <= adc_ctrl_pkg::ST_CONV;
            clk_cnt <= 5'h00;
          end else if (adc_tick) begin
            clk_cnt <= clk_cnt + 5'h1;
          end
        end
        adc_ctrl_pkg::ST_CONV: begin
          if (conv_end) begin
            state <= adc_ctrl_pkg::ST_IDLE;
            result_high <= {conv_chan, sample[11:8]};
            result_low <= sample[7:0];
          end else if (adc_tick) begin
            clk_cnt <= clk_cnt + 5'h1;
          end
        end
        default: state <= adc_ctrl_pkg::ST_IDLE;
      endcase
    end
  end

  // ****************************************
  // Analog and DMA outputs
  // ****************************************
  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      o_ref_power_en <= 1'b0;
      o_core_power_en <= 1'b0;
      o_core_standby <= 1'b0;
      o_track <= 1'b0;
      o_sar_clk_en <= 1'b0;
      o_mux_chan <= 4'h0;
      o_conv_done_flag <= 1'b0;
      o_dma_req <= 1'b0;
      o_dma_sample <= 12'h000;
      o_dma_chan <= 4'h0;
    end else begin
      o_ref_power_en <= 1'b1;
      o_core_power_en <= (timing.power_mode == `PWR_NORMAL) || !idle
        || (timing.power_mode == `PWR_STBY_IDLE);
      o_core_standby <= (timing.power_mode == `PWR_STBY_IDLE) && idle;
      o_track <= (state == adc_ctrl_pkg::ST_ACQ);
      o_sar_clk_en <= adc_tick && !idle;
      o_mux_chan <= idle ? next_chan : conv_chan;
      o_conv_done_flag <= mode.conv_done_flag;
      o_dma_req <= conv_end && mode.dma_en;
      if (conv_end) begin
        o_dma_sample <= sample;
        o_dma_chan <= conv_chan;
      end
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (i_sys_rst);

  // The start and ending of a conversion, and the DMA request pulse, are named so the properties read as a timeline.
  sequence s_started;
    idle && start;
  endsequence

  sequence s_single_end;
    conv_end && mode.single_conv_req;
  endsequence

  sequence s_dma_done;
    conv_end && mode.dma_en;
  endsequence

  sequence s_req_pulse;
    o_dma_req ##1 !o_dma_req;
  endsequence

  trigger_ignore_a: assert property (!idle |=> $stable(conv_chan))
    else $error("channel reloaded while busy");
  acq_follows_a: assert property (s_started |=> state == adc_ctrl_pkg::ST_ACQ)
    else $error("no acquisition after start");
  track_acq_a: assert property (state == adc_ctrl_pkg::ST_ACQ |=> o_track)
    else $error("track not shown");
  chan_tag_a: assert property (conv_end |=> result_high[7:4] == $past(conv_chan))
    else $error("channel tag wrong");
  result_low_a: assert property (conv_end |=> result_low == 8'($past(sample)))
    else $error("low result wrong");
  mux_hold_a: assert property (!idle |=> o_mux_chan == $past(conv_chan))
    else $error("mux moved while busy");
  single_clear_a: assert property (conv_end && !wr_mode |=> !mode.single_conv_req)
    else $error("single request not cleared");
  flag_set_a: assert property (s_single_end |=> mode.conv_done_flag)
    else $error("done flag not set");
  flag_out_a: assert property (s_single_end |=> ##1 o_conv_done_flag)
    else $error("done flag not shown");
  dma_pulse_a: assert property (s_dma_done |=> s_req_pulse)
    else $error("sample request not a single pulse");
  ref_on_a: assert property (!$past(i_sys_rst) |-> o_ref_power_en)
    else $error("reference off");
  pwr_down_a: assert property (timing.power_mode == `PWR_DOWN && idle
    |=> !o_core_power_en) else $error("core powered in power down");
  standby_a: assert property (timing.power_mode == `PWR_STBY_IDLE && idle
    |=> o_core_standby) else $error("standby not entered");
  busy_awake_a: assert property (!idle |=> o_core_power_en && !o_core_standby)
    else $error("core asleep while busy");
  div_bound_a: assert property ({1'b0, div_cnt} < div_len || idle)
    else $error("divider overrun");
  conv_len_a: assert property (clk_cnt < `CONV_CLKS) else $error("conversion too long");
  timer_arm_a: assert property (timing.timer_trigger_en && i_timer2_ovf |=> timer_armed)
    else $error("timer trigger not armed");
  ext_min_a: assert property ($fell(i_ext_convert_n) |-> !ext_trig)
    else $error("external pulse taken too early");
  cal_load_a: assert property ($past(i_sys_rst) |-> o_offset_cal == FACTORY_OFFSET
    && o_gain_cal == FACTORY_GAIN) else $error("calibration not loaded");
  // A register write in the ending cycle may legally stop the restart.
  cont_restart_a: assert property (conv_end && mode.continuous_conv_en && powered
    && !wr_mode && !wr_timing |=> ##1 state == adc_ctrl_pkg::ST_ACQ)
    else $error("no restart");

endmodule
`default_nettype wire

// [adc_conversion_control_bench.sv]
`include "adc_ctrl_params.svh"
`default_nettype none
module adc_conversion_control_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk = 1'b0;
  logic sys_rst = 1'b1;
  adc_ctrl_pkg::sfr_req_t sfr = '0;
  logic vec_ack = 1'b0;
  logic [3:0] dma_id = 4'h7;
  logic [7:0] rdata, sfr_rdata, offs, gain;
  logic [11:0] sar_code, dma_sample;
  logic sar_temp, t2_ovf, ext_n, ref_en, core_en, stby, track, tick, flag, dma_req;
  logic [3:0] mux, dma_chan;
  int mismatches = 0;
  int comparisons = 0;
  int trk = 0;
  int tck = 0;
  always #4 mclk = ~mclk;
  adc_conversion_control adc_conversion_control_inst (.i_mclk(mclk), .i_sys_rst(sys_rst),
    .i_sfr(sfr), .o_sfr_rdata(sfr_rdata), .i_timer2_ovf(t2_ovf), .i_ext_convert_n(ext_n),
    .i_int_vector_ack(vec_ack), .i_sar_code(sar_code), .i_sar_bit_temp(sar_temp),
    .o_ref_power_en(ref_en), .o_core_power_en(core_en), .o_core_standby(stby),
    .o_track(track), .o_sar_clk_en(tick), .o_mux_chan(mux), .o_conv_done_flag(flag),
    .i_dma_chan_id(dma_id), .o_dma_req(dma_req), .o_dma_sample(dma_sample),
    .o_dma_chan(dma_chan), .o_offset_cal(offs), .o_gain_cal(gain));
  adc_far_side adc_far_side_inst (.i_mclk(mclk), .i_mux_chan(mux), .o_sar_code(sar_code),
    .o_sar_bit_temp(sar_temp), .o_timer2_ovf(t2_ovf), .o_ext_convert_n(ext_n));
  // Acquisition cycles, and converter ticks after acquisition until done.
  always @(posedge mclk) begin
    if (track === 1'b1) trk++;
    if (tick === 1'b1 && track === 1'b0 && trk > 0 && flag === 1'b0) tck++;
  end
  // ****************
  // Access tasks
  // ****************
  task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
    comparisons++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk) sfr <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge mclk) sfr <= '0;
  endtask
  task automatic rd_chk(input string name, input logic [7:0] a, input logic [7:0] exp);
    @(posedge mclk) sfr <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(posedge mclk) sfr <= '0;
    #1 rdata = sfr_rdata;
    chk(name, {8'h00, exp}, {8'h00, rdata});
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask
  task automatic ack();
    @(posedge mclk) vec_ack <= 1'b1;
    @(posedge mclk) vec_ack <= 1'b0;
    idle(2);
  endtask
  task automatic wait_done(input bit dma);
    int n;
    n = 0;
    while ((dma ? dma_req : flag) !== 1'b1 && n < 1000) begin
      idle(1);
      n++;
    end
    chk("done_wait", 16'h0001, {15'h0, n < 1000});
  endtask
  task automatic test_done();
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  // ****************
  // Tests
  // ****************
  initial begin
    idle(5000);
    mismatches++;
    $display("mismatch watchdog expected done seen hang");
    test_done();
  end
  initial begin
    repeat (2) @(posedge mclk);
    sys_rst <= 1'b0;
    rd_chk("timing", `ADDR_TIMING_CTRL, 8'h20);
    rd_chk("mode", `ADDR_MODE_CTRL, 8'h00);
    rd_chk("gain_cal", `ADDR_GAIN_CAL, 8'h80);
    rd_chk("unmapped", 8'h90, 8'h00);
    wr(`ADDR_OFFSET_CAL, 8'h3c);
    rd_chk("offset_cal", `ADDR_OFFSET_CAL, 8'h3c);
    chk("offset_out", 16'h003c, {8'h00, offs});
    chk("gain_out", 16'h0080, {8'h00, gain});
    $display("test registers done");
    wr(`ADDR_TIMING_CTRL, 8'h00);
    wr(`ADDR_MODE_CTRL, 8'h11);
    idle(100);
    chk("refused_flag", 16'h0, {15'h0, flag});
    chk("ref_power", 16'h1, {15'h0, ref_en});
    chk("core_power", 16'h0, {15'h0, core_en});
    wr(`ADDR_MODE_CTRL, 8'h00);
    wr(`ADDR_TIMING_CTRL, 8'h80);
    idle(4);
    chk("idle_down", 16'h0, {15'h0, core_en});
    wr(`ADDR_TIMING_CTRL, 8'hc0);
    idle(4);
    chk("standby", 16'h1, {15'h0, stby});
    $display("test power done");
    for (int k = 0; k < 4; k++) begin
      wr(`ADDR_TIMING_CTRL, {2'b01, k[1:0], k[1:0], 2'b00});
      #1 trk = 0;
      tck = 0;
      wr(`ADDR_MODE_CTRL, 8'h13);
      wait_done(1'b0);
      chk("track_cycles", 16'(1 << (2 * k)), 16'(trk));
      chk("conv_ticks", 16'd17, 16'(tck));
      rd_chk("mode", `ADDR_MODE_CTRL, 8'h83);
      rd_chk("result_high", `ADDR_RESULT_HIGH, 8'h33);
      rd_chk("result_low", `ADDR_RESULT_LOW, 8'hc3);
      ack();
      chk("flag_clear", 16'h0, {15'h0, flag});
    end
    $display("test timing done");
    wr(`ADDR_MODE_CTRL, 8'h18);
    wait_done(1'b0);
    rd_chk("temp_high", `ADDR_RESULT_HIGH, 8'h80);
    rd_chk("temp_low", `ADDR_RESULT_LOW, 8'h01);
    ack();
    wr(`ADDR_TIMING_CTRL, 8'h41);
    wr(`ADDR_MODE_CTRL, 8'h05);
    idle(1);
    chk("mux_idle", 16'h0005, {12'h000, mux});
    adc_far_side_inst.ext_pulse(14);
    idle(80);
    rd_chk("ext_high", `ADDR_RESULT_HIGH, 8'h55);
    wr(`ADDR_TIMING_CTRL, 8'h42);
    wr(`ADDR_MODE_CTRL, 8'h06);
    adc_far_side_inst.ovf_pulse();
    idle(80);
    rd_chk("timer_first", `ADDR_RESULT_HIGH, 8'h55);
    adc_far_side_inst.ovf_pulse();
    idle(80);
    rd_chk("timer_second", `ADDR_RESULT_HIGH, 8'h66);
    $display("test triggers done");
    wr(`ADDR_TIMING_CTRL, 8'h40);
    ack();
    trk = 0;
    tck = 0;
    wr(`ADDR_MODE_CTRL, 8'h23);
    idle(200);
    chk("continuous", 16'h1, {15'h0, tck >= 51});
    wr(`ADDR_MODE_CTRL, 8'h00);
    idle(40);
    wr(`ADDR_MODE_CTRL, 8'h42);
    wait_done(1'b1);
    chk("dma_chan", 16'h7, {12'h0, dma_chan});
    chk("dma_sample", 16'h0783, {4'h0, dma_sample});
    wr(`ADDR_MODE_CTRL, 8'h00);
    $display("test streams done");
    test_done();
  end
endmodule
`default_nettype wire

// [adc_ctrl_params.svh]
`ifndef ADC_CTRL_PARAMS_SVH
`define ADC_CTRL_PARAMS_SVH

`define ADDR_MODE_CTRL 8'hd8
`define ADDR_TIMING_CTRL 8'hef
`define ADDR_RESULT_LOW 8'hd9
`define ADDR_RESULT_HIGH 8'hda
`define ADDR_OFFSET_CAL 8'hdb
`define ADDR_GAIN_CAL 8'hdc
`define RST_MODE_CTRL 8'h00
`define RST_TIMING_CTRL 8'h20
`define CONV_CLKS 5'h11
`define PWR_DOWN 2'h0
`define PWR_NORMAL 2'h1
`define PWR_DOWN_IDLE 2'h2
`define PWR_STBY_IDLE 2'h3
`define EXT_PULSE_NS 100
`define CLK_NS 8
`define EXT_PULSE_CYC ((`EXT_PULSE_NS + `CLK_NS - 1) / `CLK_NS)
`define TEMP_CHAN 4'h8

`endif

// [adc_ctrl_pkg.sv]
`default_nettype none
package adc_ctrl_pkg;

  typedef struct packed {
    logic [1:0] power_mode;
    logic [1:0] clk_div;
    logic [1:0] acq_time;
    logic timer_trigger_en;
    logic ext_trigger_en;
  } timing_ctrl_t;

  typedef struct packed {
    logic conv_done_flag;
    logic dma_en;
    logic continuous_conv_en;
    logic single_conv_req;
    logic [3:0] chan_sel;
  } mode_ctrl_t;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } sfr_req_t;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_ACQ = 3'b010,
    ST_CONV = 3'b100
  } conv_state_t;

endpackage
`default_nettype wire

// [adc_far_side.sv]
`default_nettype none
module adc_far_side (
  // Clock.
  input wire logic i_mclk,
  // Converter core.
  input wire logic [3:0] i_mux_chan,
  output logic [11:0] o_sar_code,
  output logic o_sar_bit_temp,
  // Triggers.
  output logic o_timer2_ovf,
  output logic o_ext_convert_n
);
  timeunit 1ns;
  timeprecision 1ps;
  // The code names its channel so a wrong mux shows in the result.
  assign o_sar_code = {i_mux_chan, ~i_mux_chan, 4'h3};
  assign o_sar_bit_temp = 1'b1;
  initial begin
    o_timer2_ovf = 1'b0;
    o_ext_convert_n = 1'b1;
  end
  task automatic ovf_pulse();
    @(posedge i_mclk) o_timer2_ovf <= 1'b1;
    @(posedge i_mclk) o_timer2_ovf <= 1'b0;
  endtask
  task automatic ext_pulse(input int cycles);
    @(posedge i_mclk) o_ext_convert_n <= 1'b0;
    repeat (cycles) @(posedge i_mclk);
    o_ext_convert_n <= 1'b1;
  endtask
endmodule
`default_nettype wire
